/* core/mfse_consts.svh */
/*
  Addresses, field positions, command codes and counts of the frame security engine.
  Assumes a byte-wide register port with a 9-bit address.
*/
`ifndef MFSE_CONSTS_SVH
`define MFSE_CONSTS_SVH
`define MFSE_FIRST_KEY_SLOT_ADDR    9'h100
`define MFSE_RXNONCE_ADDR 9'h110
`define MFSE_SABUF_ADDR   9'h120
`define MFSE_SECOND_KEY_SLOT_ADDR    9'h130
`define MFSE_TXNONCE_ADDR 9'h140
`define MFSE_RAM_TOP      9'h15F
`define MFSE_CMD_ADDR     9'h1F0
`define MFSE_SEC0_ADDR    9'h1F1
`define MFSE_SEC1_ADDR    9'h1F2
`define MFSE_SEC2_ADDR    9'h1F3
`define MFSE_STAT_ADDR    9'h1F4
`define MFSE_TXPUSH_ADDR  9'h1F5
`define MFSE_RXQ_ADDR     9'h1F6
`define MFSE_CMD_SA       8'h01
`define MFSE_CMD_TXENC    8'h02
`define MFSE_CMD_TXON     8'h03
`define MFSE_CMD_TXONCCA  8'h04
`define MFSE_CMD_RXDEC    8'h05
`define MFSE_MODE_OFF     2'h0
`define MFSE_MODE_CBC     2'h1
`define MFSE_MODE_CTR     2'h2
`define MFSE_MODE_CCM     2'h3
`define MFSE_SEC0_TXKEY   2
`define MFSE_SEC0_RXKEY   3
`define MFSE_SEC0_SAKEY   4
`define MFSE_ROUND_LAST   4'h9
`endif

/* core/mfse_core.sv */
/*
  Frame security engine: security RAM, transmit and receive queues, keyed block
  cipher, stand-alone, CTR, CBC-MAC and CCM operations, receive byte link.
  Assumes a host on the byte register port, a radio serial link on rf_clk/rf_data
  sampled by sys_clk (10 MHz), and a clear-channel level on cca_clear.
*/
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
`include "mfse_consts.svh"
module mfse_core #(
  parameter int unsigned RX_THRESH = 8
) (
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire mfse_pkg::mfse_bus_t bus,
  output logic [7:0]              rd_data,
  input  wire logic               rf_clk,
  input  wire logic               rf_data,
  input  wire logic               cca_clear,
  output logic                    crypto_busy_flag,
  output logic                    rx_bytes_available_pin,
  output logic                    rx_threshold_pin,
  output logic                    radio_tx_start
);
  mfse_pkg::mfse_st_t st;
  mfse_pkg::mfse_st_t n;
  logic [7:0] mem [0:`MFSE_RAM_TOP];
  logic       mem_we;
  logic [8:0] mem_wa;
  logic [7:0] mem_wd;
  logic [8:0] ea;
  logic [7:0] eb;

  // Queue byte address: transmit queue in the low 128 bytes, receive queue above.
  function automatic logic [8:0] qaddr(input mfse_pkg::mfse_op_t op, input logic [6:0] p);
    return {1'b0, op == mfse_pkg::OP_RX, p};
  endfunction : qaddr

  // One keyed mixing round of the block cipher.
  function automatic logic [127:0] mix(input logic [127:0] s, input logic [127:0] k);
    logic [127:0] t;
    t = s ^ k;
    return {t[94:0], t[127:95]} ^ (t + {t[63:0], t[127:64]});
  endfunction : mix

  // Engine read address; slot and nonce bases are fixed RAM locations.
  always_comb begin
    logic sel;
    sel = (st.op == mfse_pkg::OP_SA) ? st.sec0[`MFSE_SEC0_SAKEY] :
          (st.op == mfse_pkg::OP_TX) ? st.sec0[`MFSE_SEC0_TXKEY] : st.sec0[`MFSE_SEC0_RXKEY];
    unique case (st.state)
      mfse_pkg::S_KEY:      ea = (sel ? `MFSE_SECOND_KEY_SLOT_ADDR : `MFSE_FIRST_KEY_SLOT_ADDR) + {5'h0, st.idx};
      mfse_pkg::S_NONCE:    ea = ((st.op == mfse_pkg::OP_SA) ? `MFSE_SABUF_ADDR :
                                  (st.op == mfse_pkg::OP_RX) ? `MFSE_RXNONCE_ADDR :
                                  `MFSE_TXNONCE_ADDR) + {5'h0, st.idx};
      mfse_pkg::S_SA_STORE: ea = `MFSE_SABUF_ADDR + {5'h0, st.idx};
      default:              ea = qaddr(st.op, st.pos);
    endcase
  end
  assign eb = mem[ea];

  // Next-state logic: engine first, then radio bytes, then the register port.
  always_comb begin
    logic       ctrm;
    logic       auth;
    logic [7:0] b;
    logic [7:0] e;
    logic [7:0] len;
    logic [4:0] p;
    logic [7:0] code;
    logic [6:0] rx_len;
    ctrm = st.sec0[1:0] == `MFSE_MODE_CTR || st.sec0[1:0] == `MFSE_MODE_CCM;
    auth = st.sec0[1:0] == `MFSE_MODE_CBC || st.sec0[1:0] == `MFSE_MODE_CCM;
    b = eb;
    e = eb;
    len = eb;
    p = '0;
    code = bus.wdata;
    rx_len = mem[{2'b01, st.rx_base}][6:0];
    n = st;
    mem_we = 1'b0;
    mem_wa = ea;
    mem_wd = '0;
    n.tx_start = 1'b0;
    n.rc1 = rf_clk;
    n.rc2 = st.rc1;
    n.rc3 = st.rc2;
    n.rd1 = rf_data;
    n.rd2 = st.rd1;
    n.cc1 = cca_clear;
    n.cc2 = st.cc1;
    unique case (st.state)
      mfse_pkg::S_IDLE: begin
        // Command strobes are only looked at here, so any command strobe during an operation is dropped.
        if (bus.wr && bus.addr == `MFSE_CMD_ADDR) begin
          n.idx = '0;
          if (code == `MFSE_CMD_SA) begin
            n.op = mfse_pkg::OP_SA;
            n.busy = 1'b1;
            n.state = mfse_pkg::S_KEY;
          end else if (code == `MFSE_CMD_TXENC || code == `MFSE_CMD_TXON ||
                       (code == `MFSE_CMD_TXONCCA && st.cc2)) begin
            if (st.sec0[1:0] != `MFSE_MODE_OFF) begin
              n.op = mfse_pkg::OP_TX;
              n.launch = code != `MFSE_CMD_TXENC;
              n.base = '0;
              n.pos = '0;
              n.busy = 1'b1;
              n.state = mfse_pkg::S_KEY;
            end else if (code != `MFSE_CMD_TXENC) begin
              n.tx_start = 1'b1;
            end
          end else if (code == `MFSE_CMD_RXDEC && st.sec0[1:0] != `MFSE_MODE_OFF) begin
            n.op = mfse_pkg::OP_RX;
            n.base = st.rx_base;
            n.pos = st.rx_base;
            n.rx_block = 1'b1;
            n.busy = 1'b1;
            n.state = mfse_pkg::S_KEY;
          end
        end
      end
      mfse_pkg::S_KEY: begin
        n.key[{st.idx, 3'b000} +: 8] = eb;
        n.idx = st.idx + 4'h1;
        if (st.idx == 4'hF) begin
          n.state = (st.op != mfse_pkg::OP_SA && st.sec0[1:0] == `MFSE_MODE_CBC) ?
                    mfse_pkg::S_SETUP : mfse_pkg::S_NONCE;
        end
      end
      mfse_pkg::S_NONCE: begin
        n.nonce[{st.idx, 3'b000} +: 8] = eb;
        n.idx = st.idx + 4'h1;
        if (st.idx == 4'hF) begin
          n.state = mfse_pkg::S_SETUP;
          if (st.op == mfse_pkg::OP_SA) begin
            n.blk = n.nonce;
            n.rk = st.key;
            n.rnd = '0;
            n.ret = mfse_pkg::S_SA_STORE;
            n.state = mfse_pkg::S_CIPH;
          end
        end
      end
      mfse_pkg::S_SETUP: begin
        // Frame extent comes from the length byte at the frame base.
        p = (st.op == mfse_pkg::OP_TX) ? st.sec1[4:0] : st.sec2[4:0];
        // Widened before the add so that a code of seven gives sixteen, not zero.
        n.mlen = auth ? ({1'b0, st.sec0[7:5], 1'b0} + 5'h2) : 5'h0;
        n.ctr = st.nonce[15:0];
        n.mac = '0;
        n.mic_ok = 1'b1;
        if (st.sec0[1:0] == `MFSE_MODE_CCM) begin
          n.pos = st.base + 7'h1;
          n.cnt = len - {3'h0, n.mlen};
          n.skip = p;
        end else begin
          n.pos = st.base + 7'h1 + {2'h0, p};
          n.cnt = len - {3'h0, n.mlen} - {3'h0, p};
          n.skip = '0;
        end
        n.state = mfse_pkg::S_KS;
      end
      mfse_pkg::S_KS: begin
        n.idx = '0;
        n.acc = '0;
        if (st.cnt == 8'h00) begin
          n.state = mfse_pkg::S_MIC;
        end else if (ctrm) begin
          n.blk = {st.nonce[127:16], st.ctr};
          n.ctr = st.ctr + 16'h0001;
          n.rk = st.key;
          n.rnd = '0;
          n.ret = mfse_pkg::S_DATA;
          n.state = mfse_pkg::S_CIPH;
        end else begin
          n.state = mfse_pkg::S_DATA;
        end
      end
      mfse_pkg::S_DATA: begin
        // The keystream stays in blk for the whole block.
        if (ctrm && st.skip == 5'h0) begin
          e = b ^ st.blk[{st.idx, 3'b000} +: 8];
          mem_we = 1'b1;
          mem_wd = e;
        end
        n.acc[{st.idx, 3'b000} +: 8] = (st.op == mfse_pkg::OP_TX) ? b : e;
        n.skip = (st.skip == 5'h0) ? 5'h0 : st.skip - 5'h1;
        n.cnt = st.cnt - 8'h01;
        n.pos = st.pos + 7'h1;
        n.idx = st.idx + 4'h1;
        if (st.cnt == 8'h01 || st.idx == 4'hF) begin
          n.state = mfse_pkg::S_KS;
          if (auth) begin
            n.blk = st.mac ^ n.acc;
            n.rk = st.key;
            n.rnd = '0;
            n.ret = mfse_pkg::S_MACD;
            n.state = mfse_pkg::S_CIPH;
          end
        end
      end
      mfse_pkg::S_MACD: begin
        n.mac = st.blk;
        n.state = mfse_pkg::S_KS;
      end
      mfse_pkg::S_CIPH: begin
        n.blk = mix(st.blk, st.rk);
        n.rk = {st.rk[118:0], st.rk[127:119]} ^ {124'h0, st.rnd};
        n.rnd = st.rnd + 4'h1;
        if (st.rnd == `MFSE_ROUND_LAST) begin
          n.state = st.ret;
        end
      end
      mfse_pkg::S_MIC: begin
        // The length counts down, so a sixteen-byte code ends although idx wraps.
        if (st.mlen == 5'h0) begin
          n.state = mfse_pkg::S_IDLE;
          n.busy = 1'b0;
          n.rx_block = 1'b0;
          n.tx_start = st.launch;
          n.launch = 1'b0;
          if (st.launch) begin
            n.tx_wr = '0;
          end
        end else begin
          n.pos = st.pos + 7'h1;
          n.idx = st.idx + 4'h1;
          n.mlen = st.mlen - 5'h1;
          if (st.op == mfse_pkg::OP_TX) begin
            mem_we = 1'b1;
            mem_wd = st.mac[{st.idx, 3'b000} +: 8];
          end else begin
            n.mic_ok = st.mic_ok && (b == st.mac[{st.idx, 3'b000} +: 8]);
            if (st.mlen == 5'h1) begin
              mem_we = 1'b1;
              mem_wd = n.mic_ok ? 8'h00 : 8'hFF;
            end
          end
        end
      end
      mfse_pkg::S_SA_STORE: begin
        mem_we = 1'b1;
        mem_wd = st.blk[{st.idx, 3'b000} +: 8];
        n.idx = st.idx + 4'h1;
        if (st.idx == 4'hF) begin
          n.state = mfse_pkg::S_IDLE;
          n.busy = 1'b0;
        end
      end
    endcase
    // Radio link: bits are shifted in on rising link-clock edges, MSB first.
    if (st.rc2 && !st.rc3) begin
      n.sh = {st.sh[5:0], st.rd2};
      n.bitc = st.bitc + 3'h1;
      if (st.bitc == 3'h7 && !mem_we) begin
        mem_we = 1'b1;
        mem_wa = {2'b01, st.rx_wr};
        mem_wd = {st.sh, st.rd2};
        n.rx_wr = st.rx_wr + 7'h1;
      end
    end
    // Register port; read data stands only in the cycle after the strobe.
    n.rd_data = 8'h00;
    if (bus.addr <= `MFSE_RAM_TOP) begin
      if (bus.rd || bus.wr) begin
        n.rd_data = mem[bus.addr];
      end
      if (bus.wr && !mem_we) begin
        mem_we = 1'b1;
        mem_wa = bus.addr;
        mem_wd = bus.wdata;
      end
    end else if (bus.rd || bus.wr) begin
      unique case (bus.addr)
        `MFSE_SEC0_ADDR: n.rd_data = st.sec0;
        `MFSE_SEC1_ADDR: n.rd_data = st.sec1;
        `MFSE_SEC2_ADDR: n.rd_data = st.sec2;
        `MFSE_STAT_ADDR: n.rd_data = {6'h0, st.rx_block, st.busy};
        `MFSE_RXQ_ADDR:  n.rd_data = mem[{2'b01, st.rx_rd}];
        default:         n.rd_data = 8'h00;
      endcase
      if (bus.wr) begin
        if (bus.addr == `MFSE_SEC0_ADDR) n.sec0 = bus.wdata;
        if (bus.addr == `MFSE_SEC1_ADDR) n.sec1 = bus.wdata;
        if (bus.addr == `MFSE_SEC2_ADDR) n.sec2 = bus.wdata;
        if (bus.addr == `MFSE_TXPUSH_ADDR && !mem_we) begin
          mem_we = 1'b1;
          mem_wa = {2'b00, st.tx_wr};
          mem_wd = bus.wdata;
          n.tx_wr = st.tx_wr + 7'h1;
        end
        if (bus.addr == `MFSE_RXQ_ADDR && !mem_we) begin
          mem_we = 1'b1;
          mem_wa = {2'b01, st.rx_wr};
          mem_wd = bus.wdata;
          n.rx_wr = n.rx_wr + 7'h1;
        end
      end else if (bus.addr == `MFSE_RXQ_ADDR && st.rx_rd != st.rx_wr) begin
        // Popping past the oldest frame's end while the engine is not busy moves the frame base on.
        n.rx_rd = st.rx_rd + 7'h1;
        if (n.rx_rd == st.rx_base + rx_len + 7'h1 && !st.busy) begin
          n.rx_base = n.rx_rd;
        end
      end
    end
    n.avail = (n.rx_wr != n.rx_rd) && !n.rx_block;
    n.thr = (7'(n.rx_wr - n.rx_rd) >= 7'(RX_THRESH)) && !n.rx_block;
  end

  // State register; reset leaves the engine idle with empty queues.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  // Shared byte RAM for queues and security data.
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign rd_data = st.rd_data;
  assign crypto_busy_flag = st.busy;
  assign rx_bytes_available_pin = st.avail;
  assign rx_threshold_pin = st.thr;
  assign radio_tx_start = st.tx_start;

  // Checks on the engine.
  sequence s_sa_go;
    st.state == mfse_pkg::S_IDLE && bus.wr && bus.addr == `MFSE_CMD_ADDR &&
      bus.wdata == `MFSE_CMD_SA;
  endsequence
  sequence s_rx_go;
    st.state == mfse_pkg::S_IDLE && bus.wr && bus.addr == `MFSE_CMD_ADDR &&
      bus.wdata == `MFSE_CMD_RXDEC && st.sec0[1:0] != `MFSE_MODE_OFF;
  endsequence
  property p_sa_time;
    @(posedge sys_clk) disable iff (srst)
      s_sa_go |-> ##1 crypto_busy_flag[*8] ##51 $fell(crypto_busy_flag);
  endproperty
  a_sa_time: assert property (p_sa_time) else $error("stand-alone run length wrong");
  property p_busy_ignore;
    @(posedge sys_clk) disable iff (srst)
      st.busy && st.state != mfse_pkg::S_IDLE && bus.wr && bus.addr == `MFSE_CMD_ADDR
      |=> st.op == $past(st.op) && st.launch == $past(st.launch);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("strobe taken while busy");
  property p_rx_pins;
    @(posedge sys_clk) disable iff (srst)
      s_rx_go |=> !rx_bytes_available_pin && !rx_threshold_pin && crypto_busy_flag;
  endproperty
  a_rx_pins: assert property (p_rx_pins) else $error("receive pins not dropped");
  property p_done;
    @(posedge sys_clk) disable iff (srst)
      $fell(crypto_busy_flag) |-> $past(st.state) inside {mfse_pkg::S_MIC, mfse_pkg::S_SA_STORE};
  endproperty
  a_done: assert property (p_done) else $error("busy cleared before write-back");
  property p_tx_start;
    @(posedge sys_clk) disable iff (srst)
      radio_tx_start |-> !crypto_busy_flag && $past(st.state) != mfse_pkg::S_CIPH;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("send started mid operation");
  property p_verdict;
    @(posedge sys_clk) disable iff (srst)
      st.state == mfse_pkg::S_MIC && st.op == mfse_pkg::OP_RX && mem_we && mem_wa == ea
      |-> mem_wd == 8'h00 || mem_wd == 8'hFF;
  endproperty
  a_verdict: assert property (p_verdict) else $error("bad verdict byte");
  property p_nonce_ro;
    @(posedge sys_clk) disable iff (srst)
      st.state != mfse_pkg::S_IDLE && mem_we && mem_wa == ea
      |-> !(ea[8:4] == 5'h11 || ea[8:4] == 5'h14);
  endproperty
  a_nonce_ro: assert property (p_nonce_ro) else $error("engine wrote a nonce");
  property p_key_addr;
    @(posedge sys_clk) disable iff (srst)
      st.state == mfse_pkg::S_KEY |-> ea[8:4] == 5'h10 || ea[8:4] == 5'h13;
  endproperty
  a_key_addr: assert property (p_key_addr) else $error("key read outside slots");
endmodule : mfse_core

/* core/mfse_pkg.sv */
/*
  Types of the frame security engine: bus request, states, operations, engine state.
  Assumes mfse_consts.svh supplies all numeric constants.
*/
package mfse_pkg;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mfse_bus_t;

  typedef enum logic [3:0] {S_IDLE, S_KEY, S_NONCE, S_SETUP, S_KS, S_DATA, S_MACD,
                            S_MIC, S_CIPH, S_SA_STORE} mfse_state_t;
  typedef enum logic [1:0] {OP_SA, OP_TX, OP_RX} mfse_op_t;

  typedef struct packed {
    mfse_state_t  state;
    mfse_state_t  ret;
    mfse_op_t     op;
    logic         launch;
    logic [127:0] key;
    logic [127:0] nonce;
    logic [127:0] blk;
    logic [127:0] rk;
    logic [127:0] mac;
    logic [127:0] acc;
    logic [3:0]   rnd;
    logic [3:0]   idx;
    logic [15:0]  ctr;
    logic [6:0]   base;
    logic [6:0]   pos;
    logic [7:0]   cnt;
    logic [4:0]   skip;
    logic [4:0]   mlen;
    logic         mic_ok;
    logic [7:0]   sec0;
    logic [7:0]   sec1;
    logic [7:0]   sec2;
    logic [6:0]   tx_wr;
    logic [6:0]   rx_wr;
    logic [6:0]   rx_rd;
    logic [6:0]   rx_base;
    logic [7:0]   rd_data;
    logic         busy;
    logic         rx_block;
    logic         avail;
    logic         thr;
    logic         tx_start;
    logic         rc1, rc2, rc3, rd1, rd2, cc1, cc2;
    logic [6:0]   sh;
    logic [2:0]   bitc;
  } mfse_st_t;
endpackage : mfse_pkg

/* sim/mfse_link_src.sv */
/*
  Behavioural radio-side byte source for the frame security engine bench.
  Assumes the engine samples rf_data at rising rf_clk, most significant bit first,
  and that the bench calls send once per byte from a single process.
*/
`timescale 1ns/1ns
module mfse_link_src (
  output logic rf_clk,
  output logic rf_data
);
  // The link clock stands still low outside bytes, so no stray edge reaches the engine.
  initial begin
    rf_clk  = 1'b0;
    rf_data = 1'b0;
  end

  // One byte at an 800 ns bit period; data is set half a period before each rising edge.
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rf_data = b[i];
      #400 rf_clk = 1'b1;
      #400 rf_clk = 1'b0;
    end
    // The released line shows the inverse of the last bit, so a stale value never matches.
    rf_data = ~b[0];
  endtask : send
endmodule : mfse_link_src

/* sim/testbench.sv */
/*
  Self-checking bench for the frame security engine: RAM map, stand-alone cipher,
  in-line CBC-MAC, CTR and CCM round trips between transmit and receive queues.
  Assumes the byte register port of mfse_core and the link source model.
*/
`timescale 1ns/1ns
`include "mfse_consts.svh"
module testbench;
  logic                sys_clk   = 1'b0;
  logic                srst      = 1'b1;
  mfse_pkg::mfse_bus_t bus       = '0;
  logic                cca_clear = 1'b0;
  logic [7:0]          rd_data;
  logic                rf_clk, rf_data, busy, avail, thr, txs, endp;
  logic [7:0]          q, d, cmd, pulses;
  logic [2:0]          code;
  logic [1:0]          m;
  logic [7:0]          pt [0:31];
  logic [7:0]          ct [0:31];
  logic [7:0]          mem [0:511];
  logic [127:0]        sa_ct [0:2];
  int                  n, mm, pre, len;
  int                  n_mismatch = 0;
  int                  checks     = 0;

  mfse_core #(.RX_THRESH(4)) dut_u (
    .sys_clk               (sys_clk),
    .srst                  (srst),
    .bus                   (bus),
    .rd_data               (rd_data),
    .rf_clk                (rf_clk),
    .rf_data               (rf_data),
    .cca_clear             (cca_clear),
    .crypto_busy_flag      (busy),
    .rx_bytes_available_pin(avail),
    .rx_threshold_pin      (thr),
    .radio_tx_start        (txs)
  );

  mfse_link_src link_u (
    .rf_clk (rf_clk),
    .rf_data(rf_data)
  );

  // The 10 MHz system clock.
  always #50 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One bus cycle; the answer is taken in the cycle after the strobe, the only one it stands.
  task automatic xfer(input logic [8:0] a, input logic [7:0] wd, input logic w,
                      output logic [7:0] rq);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: wd, wr: w, rd: ~w};
    @(posedge sys_clk);
    bus <= '0;
    #1 rq = rd_data;
  endtask : xfer

  // Bounded wait for the engine to go idle, counting transmit launches on the way.
  task automatic wait_idle(output logic [7:0] np, output logic at_end);
    int k;
    k  = 0;
    np = 8'h00;
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge sys_clk);
      #1 k++;
      np = np + 8'(txs);
    end
    at_end = txs;
    if (k >= 3000) n_mismatch++;
    @(posedge sys_clk);
    #1 np = np + 8'(txs);
  endtask : wait_idle

  // Watchdog: the whole sequence needs well under 40000 cycles.
  initial begin
    #4000000;
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    void'($urandom(60098));
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    // Control registers and outputs come up cleared, and an unmapped place reads zero.
    xfer(`MFSE_SEC0_ADDR, 8'h00, 1'b0, q); chk("sec0 reset", 8'h00, q);
    xfer(`MFSE_SEC1_ADDR, 8'h00, 1'b0, q); chk("sec1 reset", 8'h00, q);
    xfer(`MFSE_STAT_ADDR, 8'h00, 1'b0, q); chk("status reset", 8'h00, q);
    xfer(9'h1E0, 8'h5A, 1'b1, q);
    xfer(9'h1E0, 8'h00, 1'b0, q); chk("unmapped", 8'h00, q);
    chk("pins reset", 8'h00, {4'h0, busy, avail, thr, txs});
    // Two passes over the security RAM; the second sees each old byte returned.
    for (int p = 0; p < 2; p++) begin
      for (int a = `MFSE_FIRST_KEY_SLOT_ADDR; a <= `MFSE_RAM_TOP; a++) begin
        d = 8'($urandom);
        xfer(9'(a), d, 1'b1, q);
        if (p == 1) chk("ram prior", mem[a], q);
        mem[a] = d;
      end
    end
    // Equal nonces on both sides, block counter one, low byte first.
    for (int i = 0; i < 16; i++) begin
      d = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : 8'($urandom);
      xfer(9'(`MFSE_RXNONCE_ADDR + i), d, 1'b1, q); chk("rx nonce prior", mem[`MFSE_RXNONCE_ADDR + i], q);
      xfer(9'(`MFSE_TXNONCE_ADDR + i), d, 1'b1, q); chk("tx nonce prior", mem[`MFSE_TXNONCE_ADDR + i], q);
      mem[`MFSE_RXNONCE_ADDR + i] = d;
      mem[`MFSE_TXNONCE_ADDR + i] = d;
    end
    // Stand-alone runs with slot 0, slot 1, slot 0; a strobe in mid-run must be ignored.
    for (int k = 0; k < 3; k++) begin
      xfer(`MFSE_SEC0_ADDR, (k == 1) ? 8'h10 : 8'h00, 1'b1, q);
      xfer(`MFSE_CMD_ADDR, `MFSE_CMD_SA, 1'b1, q);
      chk("sa busy rise", 8'h01, {7'h0, busy});
      n = 0;
      while (busy === 1'b1 && n < 100) begin
        @(posedge sys_clk);
        bus <= (n == 4) ? '{addr: `MFSE_CMD_ADDR, wdata: `MFSE_CMD_SA, wr: 1'b1, rd: 1'b0} : '0;
        #1 n++;
      end
      chk("sa cycles", 8'h3A, 8'(n));
      // Restoring the plaintext hands back the ciphertext in the same writes.
      for (int i = 0; i < 16; i++) begin
        xfer(9'(`MFSE_SABUF_ADDR + i), mem[`MFSE_SABUF_ADDR + i], 1'b1, q);
        sa_ct[k][8*i +: 8] = q;
      end
    end
    chk("sa repeat", 8'h01, {7'h0, sa_ct[0] === sa_ct[2]});
    chk("sa key slots", 8'h01, {7'h0, sa_ct[0] !== sa_ct[1]});
    // With security off, tx encrypt and rx decrypt are refused; tx on just launches.
    xfer(`MFSE_SEC0_ADDR, 8'h00, 1'b1, q);
    xfer(`MFSE_CMD_ADDR, `MFSE_CMD_TXENC, 1'b1, q); chk("off txenc", 8'h00, {7'h0, busy});
    xfer(`MFSE_CMD_ADDR, `MFSE_CMD_RXDEC, 1'b1, q); chk("off rxdec", 8'h00, {7'h0, busy});
    xfer(`MFSE_CMD_ADDR, `MFSE_CMD_TXONCCA, 1'b1, q); chk("busy channel", 8'h00, {7'h0, txs});
    @(posedge sys_clk);
    cca_clear <= 1'b1;
    repeat (4) @(posedge sys_clk);
    xfer(`MFSE_CMD_ADDR, `MFSE_CMD_TXON, 1'b1, q); chk("off tx on", 8'h01, {7'h0, txs});
    @(posedge sys_clk);
    #1 chk("launch pulse", 8'h00, {7'h0, txs});
    // Round trips: CBC-MAC, CCM, CCM with wrong receive key, CTR over the radio link.
    for (int j = 0; j < 4; j++) begin
      m = (j == 0) ? `MFSE_MODE_CBC : (j == 3) ? `MFSE_MODE_CTR : `MFSE_MODE_CCM;
      code = 3'($urandom_range(1, 3));
      mm = (j == 3) ? 0 : 2 * int'(code) + 2;
      pre = $urandom_range(0, 3);
      len = 10 + mm;
      xfer(`MFSE_SEC0_ADDR, {code, 1'b0, j == 2, 1'b0, m}, 1'b1, q);
      xfer(`MFSE_SEC1_ADDR, 8'(pre), 1'b1, q);
      xfer(`MFSE_SEC2_ADDR, 8'(pre), 1'b1, q);
      for (int i = 0; i <= 10; i++) begin
        pt[i] = (i == 0) ? 8'(len) : 8'($urandom);
        xfer(`MFSE_TXPUSH_ADDR, pt[i], 1'b1, q);
      end
      cmd = (j == 3) ? `MFSE_CMD_TXENC : (j == 1) ? `MFSE_CMD_TXONCCA : `MFSE_CMD_TXON;
      xfer(`MFSE_CMD_ADDR, cmd, 1'b1, q);
      xfer(`MFSE_CMD_ADDR, `MFSE_CMD_SA, 1'b1, q);
      wait_idle(pulses, endp);
      chk("tx launches", (j == 3) ? 8'h00 : 8'h01, pulses);
      if (j != 3) chk("launch at end", 8'h01, {7'h0, endp});
      for (int i = 0; i <= len; i++) begin
        xfer(9'(i), 8'h00, 1'b0, ct[i]);
        if (i <= pre || (j == 0 && i <= 10)) chk("tx clear part", pt[i], ct[i]);
      end
      for (int i = 0; i <= len; i++) begin
        if (j == 3) link_u.send(ct[i]);
        else xfer(`MFSE_RXQ_ADDR, ct[i], 1'b1, q);
      end
      repeat (12) @(posedge sys_clk);
      #1 chk("rx avail", 8'h01, {7'h0, avail});
      chk("rx thresh", 8'h01, {7'h0, thr});
      // The length byte is read before the strobe; the frame must still be processed whole.
      xfer(`MFSE_RXQ_ADDR, 8'h00, 1'b0, q); chk("rx length", ct[0], q);
      xfer(`MFSE_CMD_ADDR, `MFSE_CMD_RXDEC, 1'b1, q);
      @(posedge sys_clk);
      #1 chk("rx avail held", 8'h00, {7'h0, avail});
      chk("rx thresh held", 8'h00, {7'h0, thr});
      chk("rx busy", 8'h01, {7'h0, busy});
      wait_idle(pulses, endp);
      chk("rx avail back", 8'h01, {7'h0, avail});
      for (int i = 1; i <= len; i++) begin
        xfer(`MFSE_RXQ_ADDR, 8'h00, 1'b0, q);
        if (i <= 10) begin
          if (j != 2 || i <= pre) chk("rx plain", pt[i], q);
        end
        else if (i < len) chk("rx mic kept", ct[i], q);
        else chk("rx mic verdict", (j == 2) ? 8'hFF : 8'h00, q);
      end
      repeat (2) @(posedge sys_clk);
      #1 chk("rx empty", 8'h00, {7'h0, avail});
      for (int i = 0; i < 2; i++) begin
        xfer(9'(`MFSE_TXNONCE_ADDR + i), 8'h00, 1'b0, q); chk("tx block count", mem[`MFSE_TXNONCE_ADDR + i], q);
        xfer(9'(`MFSE_RXNONCE_ADDR + i), 8'h00, 1'b0, q); chk("rx block count", mem[`MFSE_RXNONCE_ADDR + i], q);
      end
    end
    report_and_stop();
  end
endmodule : testbench
